/* common/ibps_consts.vh */
// constants for the interleaved bank pair sequencer
`ifndef IBPS_CONSTS_VH
`define IBPS_CONSTS_VH
// transceiver style codes
`define IBPS_STYLE_MUX 2'h0
`define IBPS_STYLE_REG 2'h1
`define IBPS_STYLE_BIDIR 2'h2
// address fields
`define IBPS_BANK_BIT 2
`define IBPS_DW_LSB 3
// burst shape
`define IBPS_BURST_WORDS 3'h4
`define IBPS_DW_STEP 1'h1
// strobe gaps between written words
`define IBPS_GAP_NORMAL 2'h1
`define IBPS_GAP_REPEAT 2'h2
`endif

/* logic/ibps_sequencer.v */
// interleaved even/odd bank pair read and write sequencer
`timescale 1ns/1ps
`include "ibps_consts.vh"

module ibps_sequencer #(
  parameter AW = 26,
  parameter WAIT_W = 4
) (
  // clock and reset
  input wire REF_CLK,
  input wire ARST_N,
  // configuration
  input wire [1:0] XCVR_STYLE,
  input wire START_REPEAT,
  input wire [WAIT_W-1:0] FIRST_WAITS,
  input wire [WAIT_W-1:0] NEXT_WAITS,
  // request side
  input wire REQ_VALID,
  input wire REQ_WRITE,
  input wire REQ_BURST,
  input wire [AW-1:0] REQ_ADDR,
  input wire [3:0] REQ_BYTE_EN,
  input wire [31:0] REQ_WDATA,
  output reg REQ_READY,
  output reg [31:0] RD_DATA,
  output reg RD_VALID,
  output reg WR_TAKEN,
  output reg DONE,
  // memory side
  input wire [31:0] MEM_RDATA,
  output reg [AW-1:0] SYSTEM_ADDRESS_BUS,
  output reg [31:0] SYSTEM_DATA_OUT,
  output reg SYSTEM_DATA_OE,
  output reg BANK_CHIP_SELECT_EVEN,
  output reg BANK_CHIP_SELECT_ODD,
  output reg EVEN_BANK_READ_ENABLE,
  output reg ODD_BANK_READ_ENABLE,
  output reg [3:0] BYTE_WRITE_STROBES
);

  // --------------------------------------------------------------
  // states
  // --------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_START = 7'h02;
  localparam [6:0] S_WAIT = 7'h04;
  localparam [6:0] S_EVEN = 7'h08;
  localparam [6:0] S_ODD = 7'h10;
  localparam [6:0] S_WDATA = 7'h20;
  localparam [6:0] S_WGAP = 7'h40;

  reg [6:0] state;
  reg [6:0] next_state;
  reg is_write;
  reg is_burst;
  reg odd_single;
  reg [1:0] style;
  reg [2:0] words_left;
  reg [WAIT_W-1:0] wait_cnt;
  reg [1:0] gap_cnt;
  reg repeat_done;
  reg [3:0] byte_en;
  reg [AW-1:0] addr;
  reg dw_pending;

  wire style_bidir = (style == `IBPS_STYLE_BIDIR);
  wire style_mux = (style == `IBPS_STYLE_MUX);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (REQ_VALID) begin
          next_state = S_START;
        end
      end
      S_START: begin
        // repeated start cycle gives slow parts more address setup
        if (START_REPEAT && !repeat_done) begin
          next_state = S_START;
        end else if (wait_cnt != {WAIT_W{1'b0}}) begin
          next_state = S_WAIT;
        end else if (is_write) begin
          next_state = S_WDATA;
        end else begin
          next_state = S_EVEN;
        end
      end
      S_WAIT: begin
        if (wait_cnt == {{(WAIT_W-1){1'b0}}, 1'b1}) begin
          next_state = is_write ? S_WDATA : S_EVEN;
        end
      end
      S_EVEN: begin
        // an even single ends on its own word, unlike word one of a burst
        if (!is_burst && !odd_single) begin
          next_state = S_IDLE;
        end else begin
          next_state = S_ODD;
        end
      end
      S_ODD: begin
        if (words_left == 3'h0) begin
          next_state = S_IDLE;
        end else if (NEXT_WAITS != {WAIT_W{1'b0}}) begin
          next_state = S_WAIT;
        end else begin
          next_state = S_EVEN;
        end
      end
      S_WDATA: begin
        next_state = (words_left == 3'h0) ? S_IDLE : S_WGAP;
      end
      S_WGAP: begin
        if (gap_cnt == 2'h1) begin
          next_state = S_WDATA;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------
  // bank read enables
  // --------------------------------------------------------------
  // the enables lead the sampling edge by a full cycle: the bank and its
  // transceiver need that cycle to put the word on the path before it is taken
  reg next_even_en;
  reg next_odd_en;

  always @* begin
    next_even_en = 1'b0;
    next_odd_en = 1'b0;
    if (next_state == S_EVEN) begin
      // one even enable shared by every even bank
      next_even_en = 1'b1;
      // odd bank kept off while the even word owns the path
      next_odd_en = 1'b0;
    end else if (next_state == S_ODD) begin
      // mux style: odd enable is path select and odd latch enable
      // one odd enable shared by every odd bank
      next_odd_en = 1'b1;
      // mux style holds even enable over both samples
      // other styles: plain per-bank memory read enables
      next_even_en = style_mux;
    end
  end

  // --------------------------------------------------------------
  // sequencing and outputs
  // --------------------------------------------------------------
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= S_IDLE;
      is_write <= 1'b0;
      is_burst <= 1'b0;
      odd_single <= 1'b0;
      style <= `IBPS_STYLE_MUX;
      words_left <= 3'h0;
      wait_cnt <= {WAIT_W{1'b0}};
      gap_cnt <= 2'h0;
      repeat_done <= 1'b0;
      byte_en <= 4'h0;
      addr <= {AW{1'b0}};
      dw_pending <= 1'b0;
      REQ_READY <= 1'b0;
      RD_DATA <= 32'h0;
      RD_VALID <= 1'b0;
      WR_TAKEN <= 1'b0;
      DONE <= 1'b0;
      SYSTEM_ADDRESS_BUS <= {AW{1'b0}};
      SYSTEM_DATA_OUT <= 32'h0;
      SYSTEM_DATA_OE <= 1'b0;
      BANK_CHIP_SELECT_EVEN <= 1'b0;
      BANK_CHIP_SELECT_ODD <= 1'b0;
      EVEN_BANK_READ_ENABLE <= 1'b0;
      ODD_BANK_READ_ENABLE <= 1'b0;
      BYTE_WRITE_STROBES <= 4'h0;
    end else begin
      state <= next_state;
      RD_VALID <= 1'b0;
      WR_TAKEN <= 1'b0;
      DONE <= 1'b0;
      REQ_READY <= (next_state == S_IDLE);
      BYTE_WRITE_STROBES <= 4'h0;
      EVEN_BANK_READ_ENABLE <= next_even_en;
      ODD_BANK_READ_ENABLE <= next_odd_en;
      if (state == S_START) begin
        repeat_done <= 1'b1;
      end
      if (wait_cnt != {WAIT_W{1'b0}} && state == S_WAIT) begin
        wait_cnt <= wait_cnt - {{(WAIT_W-1){1'b0}}, 1'b1};
      end
      case (state)
        S_IDLE: begin
          if (REQ_VALID) begin
            is_write <= REQ_WRITE;
            is_burst <= REQ_BURST && !REQ_WRITE;
            style <= XCVR_STYLE;
            odd_single <= !REQ_BURST && REQ_ADDR[`IBPS_BANK_BIT];
            words_left <= REQ_BURST ? `IBPS_BURST_WORDS - 3'h1 : 3'h0;
            wait_cnt <= FIRST_WAITS;
            repeat_done <= 1'b0;
            byte_en <= REQ_BYTE_EN;
            addr <= REQ_ADDR;
            dw_pending <= 1'b0;
            REQ_READY <= 1'b0;
            SYSTEM_ADDRESS_BUS <= REQ_BURST ? {REQ_ADDR[AW-1:`IBPS_DW_LSB], 3'h0} : REQ_ADDR;
            // both banks of the pair start at once on reads
            BANK_CHIP_SELECT_EVEN <= REQ_WRITE ? !REQ_ADDR[`IBPS_BANK_BIT] : 1'b1;
            BANK_CHIP_SELECT_ODD <= REQ_WRITE ? REQ_ADDR[`IBPS_BANK_BIT] : 1'b1;
            if (REQ_WRITE) begin
              SYSTEM_DATA_OUT <= REQ_WDATA;
              SYSTEM_DATA_OE <= 1'b1;
            end
          end else begin
            BANK_CHIP_SELECT_EVEN <= 1'b0;
            BANK_CHIP_SELECT_ODD <= 1'b0;
            SYSTEM_DATA_OE <= 1'b0;
          end
        end
        S_EVEN: begin
          // even word sampled directly
          if (!odd_single) begin
            RD_DATA <= MEM_RDATA;
            RD_VALID <= 1'b1;
          end
          // an even single finishes here; the odd slot is never opened
          if (!is_burst && !odd_single) begin
            DONE <= 1'b1;
          end
          // word two is read from the latch except in bidir style: next doubleword goes out after word one
          // (after the first pair in bidir style), so the burst never runs past its block
          if (is_burst && words_left == `IBPS_BURST_WORDS - 3'h1) begin
            if (style_bidir) begin
              dw_pending <= 1'b1;
            end else begin
              SYSTEM_ADDRESS_BUS <= {addr[AW-1:`IBPS_DW_LSB] + `IBPS_DW_STEP, 3'h0};
              addr <= {addr[AW-1:`IBPS_DW_LSB] + `IBPS_DW_STEP, 3'h0};
            end
          end
          words_left <= (words_left == 3'h0) ? 3'h0 : words_left - 3'h1;
        end
        S_ODD: begin
          // odd word comes from the latch or the direct path
          if (is_burst || odd_single) begin
            RD_DATA <= MEM_RDATA;
            RD_VALID <= 1'b1;
          end
          if (dw_pending) begin
            SYSTEM_ADDRESS_BUS <= {addr[AW-1:`IBPS_DW_LSB] + `IBPS_DW_STEP, 3'h0};
            addr <= {addr[AW-1:`IBPS_DW_LSB] + `IBPS_DW_STEP, 3'h0};
            dw_pending <= 1'b0;
          end
          words_left <= (words_left == 3'h0) ? 3'h0 : words_left - 3'h1;
          wait_cnt <= NEXT_WAITS;
          if (words_left == 3'h0) begin
            DONE <= 1'b1;
          end
        end
        S_WDATA: begin
          // one strobe set shared by both banks
          BYTE_WRITE_STROBES <= byte_en;
          EVEN_BANK_READ_ENABLE <= style_bidir && !addr[`IBPS_BANK_BIT];
          ODD_BANK_READ_ENABLE <= style_bidir && addr[`IBPS_BANK_BIT];
          WR_TAKEN <= 1'b1;
          gap_cnt <= START_REPEAT ? `IBPS_GAP_REPEAT : `IBPS_GAP_NORMAL;
          if (words_left == 3'h0) begin
            DONE <= 1'b1;
          end
        end
        S_WGAP: begin
          // strobes low for the gap
          gap_cnt <= gap_cnt - 2'h1;
          EVEN_BANK_READ_ENABLE <= style_bidir && !addr[`IBPS_BANK_BIT];
          ODD_BANK_READ_ENABLE <= style_bidir && addr[`IBPS_BANK_BIT];
        end
        default: begin
        end
      endcase
    end
  end

endmodule

/* tb/ibps_sequencer_properties.sv */
// port assertions for the interleaved bank pair sequencer
`timescale 1ns/1ps
`include "ibps_consts.vh"
module ibps_sequencer_properties (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // configuration and request side
  input wire logic [1:0] XCVR_STYLE,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_BURST,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire logic WR_TAKEN,
  input wire logic DONE,
  // memory side
  input wire logic EVEN_BANK_READ_ENABLE,
  input wire logic ODD_BANK_READ_ENABLE,
  input wire logic [3:0] BYTE_WRITE_STROBES
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic rd_burst;
  logic rd_one;
  logic [2:0] words;
  wire wr_on = |BYTE_WRITE_STROBES;
  wire ev = EVEN_BANK_READ_ENABLE;
  wire od = ODD_BANK_READ_ENABLE;
  // word count since the last taken request
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_burst <= 1'b0;
      rd_one <= 1'b0;
      words <= 3'h0;
    end else if (REQ_VALID && REQ_READY) begin
      rd_burst <= REQ_BURST & ~REQ_WRITE;
      rd_one <= ~REQ_BURST & ~REQ_WRITE;
      words <= 3'h0;
    end else if (RD_VALID) begin
      words <= words + 3'h1;
    end
  end
  sequence pair_s;
    RD_VALID ##1 RD_VALID;
  endsequence
  odd_follows_a: assert property (rd_burst && RD_VALID && !words[0] |-> pair_s)
    else $error("odd word not one clock after even");
  burst_words_a: assert property (DONE && rd_burst |-> RD_VALID && words == 3'h3)
    else $error("burst did not end on its fourth word");
  single_word_a: assert property (DONE && rd_one |-> RD_VALID && words == 3'h0)
    else $error("single read returned other than one word");
  mux_span_a: assert property (XCVR_STYLE == `IBPS_STYLE_MUX && od && !wr_on |-> ev)
    else $error("even enable missing in odd sampling");
  reg_apart_a: assert property (XCVR_STYLE == `IBPS_STYLE_REG |-> !(ev && od))
    else $error("both banks enabled together");
  reg_write_a: assert property (XCVR_STYLE == `IBPS_STYLE_REG && wr_on |-> !ev && !od)
    else $error("read enable raised during write");
  bidir_write_a: assert property (XCVR_STYLE == `IBPS_STYLE_BIDIR && wr_on |-> ev || od)
    else $error("no read enable on bidir write");
  strobe_taken_a: assert property (WR_TAKEN |-> wr_on)
    else $error("write taken without strobes");
endmodule

bind ibps_sequencer ibps_sequencer_properties i_props (.REF_CLK, .ARST_N, .XCVR_STYLE,
  .REQ_VALID, .REQ_WRITE, .REQ_BURST, .REQ_READY, .RD_VALID, .WR_TAKEN, .DONE,
  .EVEN_BANK_READ_ENABLE, .ODD_BANK_READ_ENABLE, .BYTE_WRITE_STROBES);

/* tb/ibps_bank_pair.sv */
// behavioural even/odd bank pair behind the data transceivers
`timescale 1ns/1ps
module ibps_bank_pair (
  // clock
  input wire logic clk,
  // sequencer side
  input wire logic [25:0] addr,
  input wire logic [31:0] wdata,
  input wire logic oe,
  input wire logic cs_odd,
  input wire logic rd_even,
  input wire logic rd_odd,
  input wire logic latch_en,
  input wire logic [3:0] strobes,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:31];
  logic [31:0] odd_q = 32'h0;
  logic [31:0] last = 32'h0;
  integer i;
  initial for (i = 0; i < 32; i = i + 1) mem[i] = 32'ha5a50000 + i;
  always @(posedge clk) begin
    // latch holds the odd word while the even one is sampled
    if (!rd_even || rd_odd) odd_q <= mem[{addr[6:3], 1'b1}];
    for (i = 0; i < 4; i = i + 1) begin
      if (oe && strobes[i]) mem[{addr[6:3], cs_odd}][8*i +: 8] <= wdata[8*i +: 8];
    end
    last <= rdata;
  end
  // a released path toggles so a stale word never looks valid
  always @* begin
    if (rd_odd) rdata = latch_en ? odd_q : mem[{addr[6:3], 1'b1}];
    else if (rd_even) rdata = mem[{addr[6:3], 1'b0}];
    else rdata = ~last;
  end
endmodule

/* tb/interleaved_bank_pair_sequencer_tb_top.sv */
// self-checking bench for the interleaved bank pair sequencer
`timescale 1ns/1ps
module interleaved_bank_pair_sequencer_tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] style = 2'h0;
  logic rep = 1'b0;
  logic [3:0] fw = 4'h0;
  logic [3:0] nw = 4'h0;
  logic v = 1'b0;
  logic w = 1'b0;
  logic b = 1'b0;
  logic [3:0] be = 4'hf;
  logic [25:0] a = 26'h0;
  logic [31:0] wd = 32'h0;
  logic rdy, rv, wt, dn, oe, cse, cso, re, ro;
  logic [31:0] rd, mrd, dout;
  logic [25:0] ma;
  logic [3:0] st;
  logic [31:0] got [0:3];
  integer n, t, lat, base;
  integer err_count = 0;
  integer total_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  ibps_sequencer i_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .XCVR_STYLE(style),
    .START_REPEAT(rep), .FIRST_WAITS(fw), .NEXT_WAITS(nw), .REQ_VALID(v), .REQ_WRITE(w),
    .REQ_BURST(b), .REQ_ADDR(a), .REQ_BYTE_EN(be), .REQ_WDATA(wd), .REQ_READY(rdy),
    .RD_DATA(rd), .RD_VALID(rv), .WR_TAKEN(wt), .DONE(dn), .MEM_RDATA(mrd),
    .SYSTEM_ADDRESS_BUS(ma), .SYSTEM_DATA_OUT(dout), .SYSTEM_DATA_OE(oe),
    .BANK_CHIP_SELECT_EVEN(cse), .BANK_CHIP_SELECT_ODD(cso), .EVEN_BANK_READ_ENABLE(re),
    .ODD_BANK_READ_ENABLE(ro), .BYTE_WRITE_STROBES(st));
  ibps_bank_pair i_mem (.clk(ref_clk), .addr(ma), .wdata(dout), .oe(oe), .cs_odd(cso),
    .rd_even(re), .rd_odd(ro), .latch_en(style != 2'h2), .strobes(st), .rdata(mrd));
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("Error at %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input integer g, input integer e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("Error at %0t: count %0d expected %0d", $time, g, e);
    end
  endtask
  // one request, then collect words until done, all waits bounded
  task automatic run(input logic wr, input logic bu, input logic [25:0] ad);
    integer k;
    begin
      {k, n, t, lat} = 0;
      while (rdy !== 1'b1 && k < 40) begin
        @(posedge ref_clk);
        #2 k = k + 1;
      end
      {v, w, b, a} = {1'b1, wr, bu, ad};
      @(posedge ref_clk);
      #2 v = 1'b0;
      k = 0;
      while (dn !== 1'b1 && k < 60) begin
        @(posedge ref_clk);
        #2 k = k + 1;
        if (wt === 1'b1) t = t + 1;
        if (rv === 1'b1) begin
          got[n % 4] = rd;
          if (n == 0) lat = k;
          n = n + 1;
        end
      end
      if (k >= 60) begin
        err_count = err_count + 1;
        $display("Error at %0t: no done", $time);
        final_report;
      end
    end
  endtask
  task automatic t_reads;
    integer s, i;
    for (s = 0; s < 3; s = s + 1) begin
      style = s[1:0];
      run(1'b0, 1'b1, 26'h40);
      if (s == 0) base = lat;
      chk_n(n, 4);
      for (i = 0; i < 4; i = i + 1) chk_w(got[i], 32'ha5a50010 + i);
      run(1'b0, 1'b0, 26'h40);
      chk_n(n, 1);
      chk_n(lat, base);
      chk_w(got[0], 32'ha5a50010);
      run(1'b0, 1'b0, 26'h44);
      chk_n(lat, base + 1);
      chk_w(got[0], 32'ha5a50011);
    end
    $display("burst and single reads done");
  endtask
  task automatic t_waits;
    {style, fw, nw, rep} = {2'h1, 4'h3, 4'h2, 1'b1};
    run(1'b0, 1'b1, 26'h40);
    chk_n(lat, base + 4);
    chk_w(got[3], 32'ha5a50013);
    {fw, nw, rep} = 0;
    $display("throttled read done");
  endtask
  task automatic t_write;
    integer s;
    logic [31:0] m;
    for (s = 0; s < 3; s = s + 1) begin
      {style, rep, be, wd} = {s[1:0], s[0], 4'hf >> s, 32'hc0de0000 + s};
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      run(1'b1, 1'b0, 26'h48 + 4 * s);
      chk_n(t, 1);
      run(1'b0, 1'b0, 26'h48 + 4 * s);
      chk_w(got[0], (wd & m) | ((32'ha5a50012 + s) & ~m));
    end
    $display("writes done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #2 arst_n = 1'b1;
    t_reads;
    t_waits;
    t_write;
    final_report;
  end
endmodule
